// ==== core/pll_pkg.sv ====
// Shared constants and carrier types of the synthesizer disable and mode control block.
package pll_pkg;

   // System clock period in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS = 4;

   // Register-file addresses (4-bit data) and the peripheral address (16-bit data).
   localparam logic [7:0] ADDR_MODE_SELECT      = 8'h21;
   localparam logic [7:0] ADDR_REFERENCE_SELECT = 8'h31;
   localparam logic [7:0] ADDR_DIVISION_RATIO   = 8'h41;

   // Reset values of the three registers.
   localparam logic [3:0]  MODE_RESET  = 4'h0;
   localparam logic [3:0]  REF_RESET   = 4'hF;
   localparam logic [15:0] RATIO_RESET = 16'h0000;

   // Reference code that switches the whole synthesizer off.
   localparam logic [3:0] REF_CODE_OFF = 4'hF;

   // Division mode codes of the mode-select register.
   localparam logic [3:0] MODE_OSC_OFF           = 4'h0;
   localparam logic [3:0] MODE_DIRECT_DIVISION   = 4'h1;
   localparam logic [3:0] MODE_LOW_BAND_SWALLOW  = 4'h2;
   localparam logic [3:0] MODE_HIGH_BAND_SWALLOW = 4'h3;

   // Direct division takes its ratio from the upper twelve bits of the ratio register.
   localparam int unsigned DIRECT_RATIO_LSB = 4;

   // Reference frequency in Hz for each reference code; zero means no output.
   localparam int unsigned REF_HZ [0:15] = '{
      1250, 2500, 5000, 10000, 6250, 12500, 25000, 50000,
      3000, 0, 0, 0, 1000, 9000, 100000, 0};

   // Width of the reference generator counter.
   localparam int unsigned REF_CNT_WIDTH = 20;

   // Register-file access from the processor core.
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [3:0] wdata;
   } rf_req_type;

   // Peripheral access from the processor core.
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } peri_req_type;

endpackage

// ==== core/level_sync.sv ====
// Two flip-flop synchronizer for levels that arrive from outside the clock domain.
`timescale 1ns/10ps
module level_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] sync_q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_state_type;

   sync_state_type st_q;
   sync_state_type st_d;

   if (WIDTH < 1) begin : g_bad_width
      $error("level_sync needs WIDTH of at least one.");
   end

   // The first stage feeds only the second stage.
   always_comb begin
      st_d      = st_q;
      st_d.meta = din;
      st_d.sync = st_q.meta;
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_q = st_q.sync;

endmodule

// ==== core/rate_divider.sv ====
// Programmable divider that emits one pulse for every ratio input ticks.
`timescale 1ns/10ps
module rate_divider #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             run,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] ratio,
   output logic                  pulse_q
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             pulse;
   } div_state_type;

   div_state_type  st_q;
   div_state_type  st_d;
   logic [WIDTH:0] next_cnt;

   if (WIDTH < 2) begin : g_bad_width
      $error("rate_divider needs WIDTH of at least two.");
   end

   // Count ticks while running; a ratio of zero or one passes every tick.
   always_comb begin
      st_d       = st_q;
      st_d.pulse = 1'b0;
      next_cnt   = {1'b0, st_q.cnt} + {{WIDTH{1'b0}}, 1'b1};
      if (!run) begin
         st_d.cnt = '0;
      end else if (tick) begin
         if (next_cnt >= {1'b0, ratio}) begin
            st_d.cnt   = '0;
            st_d.pulse = 1'b1;
         end else begin
            st_d.cnt = next_cnt[WIDTH-1:0];
         end
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pulse_q = st_q.pulse;

   a_pulse_cause: assert property (
      @(posedge clk) disable iff (rst) pulse_q |-> $past(run) && $past(tick))
      else $error("Divider pulsed without a running tick.");

   a_hold_count: assert property (
      @(posedge clk) disable iff (rst) (run && !tick) |=> $stable(st_q.cnt) && !pulse_q)
      else $error("Divider count moved without a tick.");

endmodule

// ==== core/pll_synth_ctrl.sv ====
// Synthesizer disable, mode select, divider and charge-pump control of the tuning core.
`timescale 1ns/10ps
module pll_synth_ctrl #(
   parameter int unsigned CLK_HZ = 1_000_000_000 / pll_pkg::CLK_PERIOD_NS
) (
   input  wire logic                  CLK,
   input  wire logic                  SYS_RST,
   input  wire logic                  CE_PIN,
   input  wire logic                  CLOCK_STOP,
   input  wire pll_pkg::rf_req_type   RF_REQ,
   output logic [3:0]                 RF_RDATA,
   input  wire pll_pkg::peri_req_type PERI_REQ,
   output logic [15:0]                PERI_RDATA,
   input  wire logic                  LOW_BAND_OSC_INPUT,
   input  wire logic                  HIGH_BAND_OSC_INPUT,
   output logic                       LOW_BAND_PULLDOWN,
   output logic                       HIGH_BAND_PULLDOWN,
   output logic                       PHASE_ERROR_OUT_HI_O,
   output logic                       PHASE_ERROR_OUT_HI_OE,
   output logic                       PHASE_ERROR_OUT_LO_O,
   output logic                       PHASE_ERROR_OUT_LO_OE,
   output logic                       SYNTH_DISABLED
);

   localparam int unsigned CW = pll_pkg::REF_CNT_WIDTH;

   typedef logic [15:0][CW-1:0] ref_table_type;

   typedef struct packed {
      logic [3:0]  mode;
      logic [3:0]  ref_sel;
      logic [15:0] ratio;
      logic [3:0]  rf_rdata;
      logic [15:0] peri_rdata;
      logic        osc_prev;
      logic        up;
      logic        dn;
      logic        eo_val;
      logic        eo_oe;
      logic        pd_low;
      logic        pd_high;
      logic        dis;
   } ctrl_type;

   // Reference period in clock cycles for each reference code.
   function automatic ref_table_type build_table();
      ref_table_type t;
      t = '0;
      for (int i = 0; i < 16; i++) begin
         if (pll_pkg::REF_HZ[i] != 0) begin
            t[i] = CW'(CLK_HZ / pll_pkg::REF_HZ[i]);
         end
      end
      return t;
   endfunction

   localparam ref_table_type REF_CNT = build_table();

   // Power-on state: registers at reset values, pins floated and pulled down.
   localparam ctrl_type CTRL_RESET = '{
      mode:    pll_pkg::MODE_RESET,
      ref_sel: pll_pkg::REF_RESET,
      ratio:   pll_pkg::RATIO_RESET,
      pd_low:  1'b1,
      pd_high: 1'b1,
      dis:     1'b1,
      default: '0};

   if (CLK_HZ / 1000 >= (1 << CW) || CLK_HZ / 100000 < 2) begin : g_bad_clk
      $error("CLK_HZ does not fit the reference counter.");
   end

   ctrl_type       st_q;
   ctrl_type       st_d;
   logic           ce_s;
   logic [1:0]     osc_s;
   logic           ref_off;
   logic           full_dis;
   logic           sel_low;
   logic           sel_high;
   logic           osc_sel;
   logic           osc_edge;
   logic [15:0]    div_ratio;
   logic [CW-1:0]  ref_ratio;
   logic           ref_run;
   logic           fr_pulse;
   logic           fn_pulse;
   logic           up_n;
   logic           dn_n;

   // Chip-enable and both oscillator pins come from outside the clock domain.
   level_sync #(.WIDTH(1)) u_ce_sync (
      .clk    (CLK),
      .rst    (SYS_RST),
      .din    (CE_PIN),
      .sync_q (ce_s)
   );

   level_sync #(.WIDTH(2)) u_osc_sync (
      .clk    (CLK),
      .rst    (SYS_RST),
      .din    ({HIGH_BAND_OSC_INPUT, LOW_BAND_OSC_INPUT}),
      .sync_q (osc_s)
   );

   // Disable condition and source selection.
   always_comb begin
      ref_off  = (st_q.ref_sel == pll_pkg::REF_CODE_OFF);
      full_dis = !ce_s || ref_off;
      sel_low  = (st_q.mode == pll_pkg::MODE_DIRECT_DIVISION) ||
                 (st_q.mode == pll_pkg::MODE_LOW_BAND_SWALLOW);
      sel_high = (st_q.mode == pll_pkg::MODE_HIGH_BAND_SWALLOW);
      osc_sel  = sel_high ? osc_s[1] : (sel_low ? osc_s[0] : 1'b0);
      osc_edge = osc_sel && !st_q.osc_prev;
      if (st_q.mode == pll_pkg::MODE_DIRECT_DIVISION) begin
         div_ratio = st_q.ratio >> pll_pkg::DIRECT_RATIO_LSB;
      end else begin
         div_ratio = st_q.ratio;
      end
      ref_ratio = REF_CNT[st_q.ref_sel];
      ref_run   = !full_dis && (ref_ratio != '0);
   end

   // Programmable counter on the selected oscillator input; stops under full disable.
   rate_divider #(.WIDTH(16)) u_prog_counter (
      .clk     (CLK),
      .rst     (SYS_RST),
      .run     (!full_dis),
      .tick    (osc_edge),
      .ratio   (div_ratio),
      .pulse_q (fn_pulse)
   );

   // Reference generator counting system clocks; prohibited codes give no output.
   rate_divider #(.WIDTH(CW)) u_ref_gen (
      .clk     (CLK),
      .rst     (SYS_RST),
      .run     (ref_run),
      .tick    (1'b1),
      .ratio   (ref_ratio),
      .pulse_q (fr_pulse)
   );

   // Registers, phase comparator and charge pump.
   always_comb begin
      st_d          = st_q;
      st_d.osc_prev = osc_sel;
      // Register writes; a chip-enable drop touches none of them.
      if (RF_REQ.wr && RF_REQ.addr == pll_pkg::ADDR_MODE_SELECT) begin
         st_d.mode = RF_REQ.wdata;
      end
      if (RF_REQ.wr && RF_REQ.addr == pll_pkg::ADDR_REFERENCE_SELECT) begin
         st_d.ref_sel = RF_REQ.wdata;
      end
      if (CLOCK_STOP) begin
         st_d.ref_sel = pll_pkg::REF_CODE_OFF;
      end
      if (PERI_REQ.wr && PERI_REQ.addr == pll_pkg::ADDR_DIVISION_RATIO) begin
         st_d.ratio = PERI_REQ.wdata;
      end
      // Read data, registered one cycle after the address.
      unique case (RF_REQ.addr)
         pll_pkg::ADDR_MODE_SELECT:      st_d.rf_rdata = st_q.mode;
         pll_pkg::ADDR_REFERENCE_SELECT: st_d.rf_rdata = st_q.ref_sel;
         default:                        st_d.rf_rdata = 4'h0;
      endcase
      if (PERI_REQ.addr == pll_pkg::ADDR_DIVISION_RATIO) begin
         st_d.peri_rdata = st_q.ratio;
      end else begin
         st_d.peri_rdata = 16'h0000;
      end
      // Up request on a reference edge, down on a divided edge, both cancel.
      up_n = st_q.up || fr_pulse;
      dn_n = st_q.dn || fn_pulse;
      if (full_dis) begin
         up_n = 1'b0;
         dn_n = 1'b0;
      end else if (up_n && dn_n) begin
         up_n = 1'b0;
         dn_n = 1'b0;
      end
      st_d.up = up_n;
      st_d.dn = dn_n;
      // Up drives low, down drives high, otherwise float; with no divided input
      // the up request persists, so the pins sit low.
      st_d.eo_oe  = !full_dis && (up_n ^ dn_n);
      st_d.eo_val = dn_n;
      // Unselected or disabled oscillator inputs are pulled down.
      st_d.pd_low  = full_dis || !sel_low;
      st_d.pd_high = full_dis || !sel_high;
      st_d.dis     = full_dis;
   end

   // State register; only power-on reset initialises the registers.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st_q <= CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign RF_RDATA              = st_q.rf_rdata;
   assign PERI_RDATA            = st_q.peri_rdata;
   assign LOW_BAND_PULLDOWN     = st_q.pd_low;
   assign HIGH_BAND_PULLDOWN    = st_q.pd_high;
   assign PHASE_ERROR_OUT_HI_O  = st_q.eo_val;
   assign PHASE_ERROR_OUT_HI_OE = st_q.eo_oe;
   assign PHASE_ERROR_OUT_LO_O  = st_q.eo_val;
   assign PHASE_ERROR_OUT_LO_OE = st_q.eo_oe;
   assign SYNTH_DISABLED        = st_q.dis;

   default clocking cb @(posedge CLK);
   endclocking

   default disable iff (SYS_RST);

   a_ce_low_float: assert property (
      !ce_s |=> !PHASE_ERROR_OUT_HI_OE && !PHASE_ERROR_OUT_LO_OE && SYNTH_DISABLED)
      else $error("Chip-enable low left the synthesizer running.");

   a_ref_off_stop: assert property (
      ref_off |=> !fr_pulse && !fn_pulse && SYNTH_DISABLED)
      else $error("Reference code all ones did not stop the synthesizer.");

   a_osc_off_pull: assert property (
      (!full_dis && st_q.mode == pll_pkg::MODE_OSC_OFF)
      |=> LOW_BAND_PULLDOWN && HIGH_BAND_PULLDOWN && !SYNTH_DISABLED)
      else $error("Oscillator-off mode did not pull both inputs down.");

   a_dis_no_request: assert property (
      full_dis |=> !st_q.up && !st_q.dn && !fn_pulse && !fr_pulse)
      else $error("Comparator request or divider output under full disable.");

   a_dis_pins: assert property (
      full_dis |=> !PHASE_ERROR_OUT_LO_OE && LOW_BAND_PULLDOWN && HIGH_BAND_PULLDOWN)
      else $error("Full disable left a pin driven or an input floating.");

   a_osc_off_low: assert property (
      (!full_dis && st_q.mode == pll_pkg::MODE_OSC_OFF && st_q.up && !fn_pulse)
      |=> PHASE_ERROR_OUT_HI_OE && !PHASE_ERROR_OUT_HI_O)
      else $error("Charge pump did not drive low without divided input.");

   a_ce_keeps_regs: assert property (
      ($changed(ce_s) && !RF_REQ.wr && !CLOCK_STOP)
      |=> $stable(st_q.mode) && $stable(st_q.ref_sel))
      else $error("Chip-enable change altered a select register.");

   a_por_disabled: assert property (
      $fell(SYS_RST) |-> SYNTH_DISABLED && st_q.ref_sel == pll_pkg::REF_CODE_OFF)
      else $error("Synthesizer not disabled after power-on reset.");

   a_clock_stop_off: assert property (
      CLOCK_STOP |=> st_q.ref_sel == pll_pkg::REF_CODE_OFF ##1 SYNTH_DISABLED)
      else $error("Clock-stop did not load the disable code.");

   a_direct_low: assert property (
      (!full_dis && st_q.mode == pll_pkg::MODE_DIRECT_DIVISION)
      |=> !LOW_BAND_PULLDOWN && HIGH_BAND_PULLDOWN)
      else $error("Direct division did not select the low-band input.");

   a_high_band_src: assert property (
      (!full_dis && st_q.mode == pll_pkg::MODE_HIGH_BAND_SWALLOW)
      |=> !HIGH_BAND_PULLDOWN && LOW_BAND_PULLDOWN)
      else $error("High-band swallow did not select the high-band input.");

   a_mode_write: assert property (
      (RF_REQ.wr && RF_REQ.addr == pll_pkg::ADDR_MODE_SELECT)
      |=> st_q.mode == $past(RF_REQ.wdata) ##1 RF_RDATA == $past(RF_REQ.wdata, 2)
          || $past(RF_REQ.addr) != pll_pkg::ADDR_MODE_SELECT)
      else $error("Mode register write at its address failed.");

   a_ratio_write: assert property (
      (PERI_REQ.wr && PERI_REQ.addr == pll_pkg::ADDR_DIVISION_RATIO)
      |=> st_q.ratio == $past(PERI_REQ.wdata))
      else $error("Division ratio write failed.");

   c_direct_lock: cover property (
      !full_dis && st_q.mode == pll_pkg::MODE_DIRECT_DIVISION && fn_pulse ##[1:8] fr_pulse);

   c_high_band_run: cover property (
      !full_dis && sel_high && fn_pulse);

   c_ce_return: cover property (
      !ce_s ##1 ce_s [*3] ##1 !SYNTH_DISABLED);

   c_clock_stop: cover property (
      !SYNTH_DISABLED ##1 CLOCK_STOP ##2 SYNTH_DISABLED);

endmodule

// ==== tb/vco_model.sv ====
// Behavioural model of the external oscillator that feeds both band inputs.
`timescale 1ns/10ps
module vco_model (
   input  wire logic       run,
   input  wire logic       low_pd,
   input  wire logic       high_pd,
   input  wire logic [7:0] half_ns,
   output logic            low_out,
   output logic            high_out
);
   logic osc = 1'b0;

   // The oscillator runs on its own time base, unrelated to the core clock.
   always begin
      #(half_ns + 1);
      osc = run ? ~osc : 1'b0;
   end

   // An enabled internal pull-down wins, because the oscillator drives weakly.
   assign low_out  = low_pd ? 1'b0 : osc;
   assign high_out = high_pd ? 1'b0 : osc;
endmodule

// ==== tb/pll_synth_ctrl_tb.sv ====
// Self-checking testbench of the synthesizer disable and mode control block.
`timescale 1ns/10ps
module pll_synth_ctrl_tb;
   logic                  clk = 1'b0;
   logic                  sys_rst = 1'b1;
   logic                  ce_pin = 1'b1;
   logic                  clock_stop = 1'b0;
   pll_pkg::rf_req_type   rf_req = '0;
   pll_pkg::peri_req_type peri_req = '0;
   logic [3:0]            rf_rdata;
   logic [15:0]           peri_rdata;
   logic                  low_osc, high_osc, low_pd, high_pd;
   logic                  hi_o, hi_oe, lo_o, lo_oe, synth_dis;
   logic                  vco_run = 1'b0;
   logic [7:0]            vco_half = 8'h13;
   int                    fail_count = 0;
   int                    n_checks = 0;
   int                    k, n_up, n_dn;

   pll_synth_ctrl #(.CLK_HZ(2_000_000)) DUT (
      .CLK(clk), .SYS_RST(sys_rst), .CE_PIN(ce_pin), .CLOCK_STOP(clock_stop),
      .RF_REQ(rf_req), .RF_RDATA(rf_rdata), .PERI_REQ(peri_req), .PERI_RDATA(peri_rdata),
      .LOW_BAND_OSC_INPUT(low_osc), .HIGH_BAND_OSC_INPUT(high_osc),
      .LOW_BAND_PULLDOWN(low_pd), .HIGH_BAND_PULLDOWN(high_pd),
      .PHASE_ERROR_OUT_HI_O(hi_o), .PHASE_ERROR_OUT_HI_OE(hi_oe),
      .PHASE_ERROR_OUT_LO_O(lo_o), .PHASE_ERROR_OUT_LO_OE(lo_oe),
      .SYNTH_DISABLED(synth_dis));

   vco_model VCO (
      .run(vco_run), .low_pd(low_pd), .high_pd(high_pd), .half_ns(vco_half),
      .low_out(low_osc), .high_out(high_osc));

   // Clock of 4 ns period.
   always #2 clk = ~clk;

   // Ends the run with the verdict.
   task automatic final_report();
      if (fail_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Compares any register or count value.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Compares the pin state: disabled, both pull-downs, both drive enables.
   task automatic pins(input logic [4:0] exp);
      chk({11'h000, synth_dis, low_pd, high_pd, hi_oe, lo_oe}, {11'h000, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Register-file write strobe, then one idle cycle.
   task automatic rf_wr(input logic [7:0] a, input logic [3:0] d);
      rf_req = '{1'b1, a, d};
      @(negedge clk);
      rf_req = '0;
      @(negedge clk);
   endtask

   task automatic rf_chk(input logic [7:0] a, input logic [3:0] exp);
      rf_req = '{1'b0, a, 4'h0};
      @(negedge clk);
      chk({12'h000, rf_rdata}, {12'h000, exp});
   endtask

   task automatic peri_wr(input logic [7:0] a, input logic [15:0] d);
      peri_req = '{1'b1, a, d};
      @(negedge clk);
      peri_req = '0;
      @(negedge clk);
   endtask

   task automatic peri_chk(input logic [7:0] a, input logic [15:0] exp);
      peri_req = '{1'b0, a, 16'h0000};
      @(negedge clk);
      chk(peri_rdata, exp);
   endtask

   // Power-on values of registers and pins.
   task automatic t_reset();
      pins(5'b1_1_1_0_0);
      rf_chk(8'h31, 4'hF);
      rf_chk(8'h21, 4'h0);
      peri_chk(8'h41, 16'h0000);
   endtask

   // Addresses of the three registers, and unmapped places read as zero.
   task automatic t_regs();
      rf_wr(8'h21, 4'h3);
      rf_wr(8'h31, 4'hE);
      peri_wr(8'h41, 16'hA5C3);
      rf_chk(8'h21, 4'h3);
      rf_chk(8'h31, 4'hE);
      peri_chk(8'h41, 16'hA5C3);
      rf_chk(8'h41, 4'h0);
      peri_chk(8'h21, 16'h0000);
   endtask

   // Codes 1 to 3 select their oscillator input; codes 7 and 0 pull down both.
   task automatic t_modes();
      logic [3:0] m [5] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h0};
      logic [1:0] pd [5] = '{2'b01, 2'b01, 2'b10, 2'b11, 2'b11};
      for (int i = 0; i < 5; i++) begin
         rf_wr(8'h21, m[i]);
         cyc(4);
         chk({13'h0000, synth_dis, low_pd, high_pd}, {13'h0000, 1'b0, pd[i]});
      end
   endtask

   // Oscillator inputs off: charge pump still runs and drives low.
   task automatic t_pump_idle();
      k = 0;
      while (hi_oe !== 1'b1 && k < 200) begin
         cyc(1);
         k++;
      end
      if (k == 200) begin
         fail_count++;
         final_report();
      end
      chk({12'h000, hi_oe, hi_o, lo_oe, lo_o}, {12'h000, 4'b1010});
   endtask

   // Counts driven-high and driven-low cycles for one division ratio.
   task automatic measure(input logic [15:0] ratio);
      peri_wr(8'h41, ratio);
      cyc(20);
      n_up = 0;
      n_dn = 0;
      repeat (600) begin
         cyc(1);
         n_up += int'(hi_oe === 1'b1 && hi_o === 1'b0);
         n_dn += int'(hi_oe === 1'b1 && hi_o === 1'b1);
      end
   endtask

   // Each band input feeds the counter in its mode; faster than reference drives high.
   task automatic t_divide();
      vco_run = 1'b1;
      rf_wr(8'h21, 4'h3);
      measure(16'h0001);
      chk(16'(n_dn > n_up), 16'h0001);
      rf_wr(8'h21, 4'h2);
      measure(16'h0001);
      chk(16'(n_dn > n_up), 16'h0001);
      rf_wr(8'h21, 4'h1);
      measure(16'h0010);
      chk(16'(n_dn > n_up), 16'h0001);
      measure(16'h0400);
      chk(16'(n_up > n_dn), 16'h0001);
   endtask

   // Chip-enable low stops everything; registers survive its return.
   task automatic t_ce();
      ce_pin = 1'b0;
      cyc(4);
      pins(5'b1_1_1_0_0);
      k = 0;
      repeat (80) begin
         cyc(1);
         k += int'(hi_oe !== 1'b0 || lo_oe !== 1'b0 || synth_dis !== 1'b1);
      end
      chk(16'(k), 16'h0000);
      ce_pin = 1'b1;
      cyc(4);
      chk({15'h0000, synth_dis}, 16'h0000);
      rf_chk(8'h21, 4'h1);
      rf_chk(8'h31, 4'hE);
      ce_pin = 1'b0;
      rf_wr(8'h31, 4'hF);
      rf_wr(8'h21, 4'h0);
      ce_pin = 1'b1;
      cyc(4);
      pins(5'b1_1_1_0_0);
   endtask

   // Clock stop beats a reference write and keeps the next chip-enable off.
   task automatic t_stop();
      rf_wr(8'h31, 4'h3);
      cyc(2);
      chk({15'h0000, synth_dis}, 16'h0000);
      rf_wr(8'h31, 4'h9);
      cyc(2);
      chk({15'h0000, synth_dis}, 16'h0000);
      clock_stop = 1'b1;
      rf_req = '{1'b1, 8'h31, 4'h5};
      @(negedge clk);
      clock_stop = 1'b0;
      rf_req = '0;
      @(negedge clk);
      rf_chk(8'h31, 4'hF);
      ce_pin = 1'b0;
      cyc(4);
      ce_pin = 1'b1;
      cyc(4);
      pins(5'b1_1_1_0_0);
      rf_wr(8'h31, 4'h3);
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      pins(5'b1_1_1_0_0);
      rf_chk(8'h31, 4'hF);
   endtask

   // Watchdog against a hang anywhere in the sequence.
   initial begin
      #100us;
      fail_count++;
      final_report();
   end

   // Main sequence.
   initial begin
      cyc(6);
      sys_rst = 1'b0;
      t_reset();
      t_regs();
      t_modes();
      t_pump_idle();
      t_divide();
      t_ce();
      t_stop();
      final_report();
   end
endmodule
